//--- shared/bcp_pkg.sv
// package of constants and types for the block copy engine and its flag unit
//
// Notes on behaviour
// [RQ1] while count nonzero, copy byte source to destination, bump pointers, decrement count
// [RQ2] a copy started with a zero count moves nothing and finishes at once
// [RQ3] byte form counts in the low eight bits, word form in all sixteen
// [RQ4] from on-chip memory the copy takes eight states plus four per byte
// [RQ5] transfers paced by a slow peripheral clock take a variable number of states
// [RQ6] first half-carry kind sets H on carry or borrow out of bit 11
// [RQ7] second half-carry kind sets H on carry or borrow out of bit 27
// [RQ8] sticky zero keeps Z for a zero result, clears it otherwise
// [RQ9] decimal adjust sets C when the adjustment carries, else keeps it
// [RQ10] signed divide flag is one when the divisor is negative, else zero
// [RQ11] divide flag is one when the divisor is zero, else zero
// [RQ12] divide flag is one when the quotient is negative, else zero
// [RQ13] split opcode entry picks its instruction from the second byte's top bit
// [RQ14] the copy instruction is four bytes long and leaves every flag alone
// [RQ15] byte form keeps the count's upper half; registers keep their final values
package bcp_pkg;

  // register byte offsets on the avalon slave
  localparam logic [7:0] OFS_INSTR  = 8'h00;
  localparam logic [7:0] OFS_SRC    = 8'h04;
  localparam logic [7:0] OFS_DST    = 8'h08;
  localparam logic [7:0] OFS_COUNT  = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_STATES = 8'h14;
  localparam logic [7:0] OFS_CCR    = 8'h18;
  localparam logic [7:0] OFS_FLAGOP = 8'h1c;
  localparam logic [7:0] OFS_OPND_A = 8'h20;
  localparam logic [7:0] OFS_OPND_B = 8'h24;

  // status register bits
  localparam int ST_BUSY    = 0;
  localparam int ST_DONE    = 1;
  localparam int ST_ILLEGAL = 2;
  localparam int ST_WORD    = 3;

  // condition code bit positions
  localparam int CCR_I = 7;
  localparam int CCR_H = 5;
  localparam int CCR_N = 3;
  localparam int CCR_Z = 2;
  localparam int CCR_V = 1;
  localparam int CCR_C = 0;
  localparam logic [7:0] CCR_RESET = 8'h80;

  // instruction decode
  localparam logic [7:0] OPC_COPY_FIRST = 8'h7b;
  localparam int         SPLIT_BIT      = 7;   // top bit of the second byte's upper nibble
  localparam int         INSTR_BYTES    = 4;

  // timing of a copy from on-chip memory, in states
  localparam int OVERHEAD_STATES = 8;
  localparam int STATES_PER_BYTE = 4;

  // half-carry tap positions
  localparam int HC_BIT_NARROW = 11;
  localparam int HC_BIT_WIDE   = 27;

  // flag unit operation select
  typedef enum logic [2:0] {
    FOP_NONE,
    FOP_HC_NARROW,
    FOP_HC_WIDE,
    FOP_STICKY_Z,
    FOP_DEC_ADJ,
    FOP_DIV_SIGN,
    FOP_DIV_ZERO,
    FOP_DIV_QUOT
  } bcp_flag_op_t;

  localparam int FOP_SUB_BIT = 3;   // flag op register: bit 3 selects subtract

endpackage : bcp_pkg

//--- shared/bcp_flag_if.sv
// interface carrying operands and flags between the engine and its flag unit
`timescale 1ns/1ps
interface bcp_flag_if;
  import bcp_pkg::*;
  bcp_flag_op_t op;
  logic         sub;
  logic [31:0]  opnd_a;
  logic [31:0]  opnd_b;
  logic [7:0]   ccr_in;
  logic [7:0]   ccr_out;

  modport calc (input op, input sub, input opnd_a, input opnd_b, input ccr_in, output ccr_out);
  modport user (output op, output sub, output opnd_a, output opnd_b, output ccr_in,
                input ccr_out);
endinterface : bcp_flag_if

//--- verilog/bcp_flag_unit.sv
// combinational condition code rules for the special-case instructions
`timescale 1ns/1ps
module bcp_flag_unit (
  bcp_flag_if.calc fl
);
  import bcp_pkg::*;

  logic [12:0] narrow_sum;
  logic [28:0] wide_sum;
  logic [32:0] full_res;
  logic        adj_carry;
  logic        divisor_neg;
  logic        divisor_zero;

  // carry out of the tap bit is the top bit of the truncated sum or difference
  always_comb begin
    if (fl.sub) begin
      narrow_sum = {1'b0, fl.opnd_a[HC_BIT_NARROW:0]} - {1'b0, fl.opnd_b[HC_BIT_NARROW:0]};
      wide_sum   = {1'b0, fl.opnd_a[HC_BIT_WIDE:0]} - {1'b0, fl.opnd_b[HC_BIT_WIDE:0]};
      full_res   = {1'b0, fl.opnd_a} - {1'b0, fl.opnd_b} - {32'h0, fl.ccr_in[CCR_C]};
    end else begin
      narrow_sum = {1'b0, fl.opnd_a[HC_BIT_NARROW:0]} + {1'b0, fl.opnd_b[HC_BIT_NARROW:0]};
      wide_sum   = {1'b0, fl.opnd_a[HC_BIT_WIDE:0]} + {1'b0, fl.opnd_b[HC_BIT_WIDE:0]};
      full_res   = {1'b0, fl.opnd_a} + {1'b0, fl.opnd_b} + {32'h0, fl.ccr_in[CCR_C]};
    end
  end

  // decimal adjust of the low byte of operand a carries when the upper digit overflows
  assign adj_carry = (fl.opnd_a[7:4] > 4'h9) ||
                     ((fl.opnd_a[7:4] == 4'h9) && (fl.opnd_a[3:0] > 4'h9));

  // divisor sits in the low half of operand b, dividend in operand a
  assign divisor_neg  = fl.opnd_b[15];
  assign divisor_zero = (fl.opnd_b[15:0] == 16'h0000);

  // each op touches only its own flag; all other bits pass through
  always_comb begin
    fl.ccr_out = fl.ccr_in;
    case (fl.op)
      FOP_HC_NARROW: fl.ccr_out[CCR_H] = narrow_sum[HC_BIT_NARROW + 1];       // [RQ6]
      FOP_HC_WIDE:   fl.ccr_out[CCR_H] = wide_sum[HC_BIT_WIDE + 1];           // [RQ7]
      FOP_STICKY_Z:  fl.ccr_out[CCR_Z] = fl.ccr_in[CCR_Z] & (full_res[31:0] == 32'h0); // [RQ8]
      FOP_DEC_ADJ:   fl.ccr_out[CCR_C] = fl.ccr_in[CCR_C] | adj_carry;        // [RQ9]
      FOP_DIV_SIGN:  fl.ccr_out[CCR_N] = divisor_neg;                         // [RQ10]
      FOP_DIV_ZERO:  fl.ccr_out[CCR_Z] = divisor_zero;                        // [RQ11]
      FOP_DIV_QUOT:  fl.ccr_out[CCR_N] = !divisor_zero & (fl.opnd_a[31] ^ divisor_neg); // [RQ12]
      default:       fl.ccr_out = fl.ccr_in;
    endcase
  end

endmodule : bcp_flag_unit

//--- verilog/bcp_block_copy.sv
// block copy engine with register file, opcode decode and flag unit
`timescale 1ns/1ps
module bcp_block_copy #(
  parameter int ADDR_W = 24
) (
  input  wire logic              clk,
  input  wire logic              rst,
  // avalon-mm slave
  input  wire logic [7:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  // byte memory port
  output logic      [ADDR_W-1:0] mem_address,
  output logic                   mem_read,
  output logic                   mem_write,
  output logic      [7:0]        mem_writedata,
  input  wire logic [7:0]        mem_readdata,
  input  wire logic              mem_ready
);
  import bcp_pkg::*;

  typedef enum logic [2:0] {
    S_IDLE,
    S_OVERHEAD,
    S_RD_SETUP,
    S_RD_DATA,
    S_WR_SETUP,
    S_WR_DATA
  } bcp_state_t;

  bcp_state_t   state;
  logic [31:0]  instr;
  logic [ADDR_W-1:0] source_pointer;
  logic [ADDR_W-1:0] destination_pointer;
  logic [15:0]  count_register;
  logic [7:0]   ccr;
  logic [31:0]  opnd_a;
  logic [31:0]  opnd_b;
  logic [3:0]   flag_op;
  logic         word_form;
  logic         done;
  logic         illegal;
  logic [31:0]  state_count;
  logic [3:0]   overhead_cnt;
  logic [7:0]   copy_byte;
  logic         resp_ph;
  logic         busy;
  logic         acc_wr;
  logic         acc_rd;
  logic         stall_wr;
  logic [31:0]  wr_merged;
  logic [31:0]  rd_value;
  logic [7:0]   second_byte;
  logic         is_copy;
  logic         is_word;
  logic         start;
  logic         count_zero;
  logic         last_byte;
  logic         done_set;
  logic         flag_load;

  bcp_flag_if fl ();

  bcp_flag_unit u_flag (
    .fl (fl.calc)
  );

  assign busy = (state != S_IDLE);

  // bus slave
  // writes to copy state while a copy runs are held off with waitrequest,
  // so software cannot corrupt pointers in flight
  assign stall_wr = avs_write && busy &&
                    (avs_address == OFS_INSTR || avs_address == OFS_SRC ||
                     avs_address == OFS_DST || avs_address == OFS_COUNT);

  // every access answers one cycle after it is first seen, unless stalled
  assign avs_waitrequest = (avs_read || avs_write) && !resp_ph;
  assign acc_wr          = avs_write && resp_ph;
  assign acc_rd          = avs_read && resp_ph;

  always_ff @(posedge clk) begin
    if (rst) begin
      resp_ph <= 1'b0;
    end else begin
      resp_ph <= (avs_read || avs_write) && !resp_ph && !stall_wr;
    end
  end

  // byte enables merge the write into the current register value
  function automatic logic [31:0] merge_be(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge_be

  // read mux; unmapped offsets read as zero
  always_comb begin
    rd_value = 32'h0;
    if (avs_address == OFS_INSTR) begin
      rd_value = instr;
    end else if (avs_address == OFS_SRC) begin
      rd_value = 32'(source_pointer);
    end else if (avs_address == OFS_DST) begin
      rd_value = 32'(destination_pointer);
    end else if (avs_address == OFS_COUNT) begin
      rd_value = {16'h0, count_register};
    end else if (avs_address == OFS_STATUS) begin
      rd_value[ST_BUSY]    = busy;
      rd_value[ST_DONE]    = done;
      rd_value[ST_ILLEGAL] = illegal;
      rd_value[ST_WORD]    = word_form;
    end else if (avs_address == OFS_STATES) begin
      rd_value = state_count;
    end else if (avs_address == OFS_CCR) begin
      rd_value = {24'h0, ccr};
    end else if (avs_address == OFS_FLAGOP) begin
      rd_value = {28'h0, flag_op};
    end else if (avs_address == OFS_OPND_A) begin
      rd_value = opnd_a;
    end else if (avs_address == OFS_OPND_B) begin
      rd_value = opnd_b;
    end
  end

  // read data is captured on the cycle the answer is prepared
  always_ff @(posedge clk) begin
    if (rst) begin
      avs_readdata <= 32'h0;
    end else if (avs_read && !resp_ph) begin
      avs_readdata <= rd_value;
    end
  end

  // decode
  // a write to the instruction register issues the four-byte word held there
  assign wr_merged   = merge_be(instr, avs_writedata, avs_byteenable);
  assign second_byte = wr_merged[23:16];
  assign is_copy     = (wr_merged[31:24] == OPC_COPY_FIRST);                 // [RQ14]
  assign is_word     = second_byte[SPLIT_BIT];                               // [RQ13]
  assign start       = acc_wr && (avs_address == OFS_INSTR) && is_copy;

  always_ff @(posedge clk) begin
    if (rst) begin
      instr <= 32'h0;
    end else if (acc_wr && avs_address == OFS_INSTR) begin
      instr <= wr_merged;
    end
  end

  // illegal marks an instruction word that is not a copy; the next copy issued clears it
  always_ff @(posedge clk) begin
    if (rst) begin
      illegal <= 1'b0;
    end else if (acc_wr && avs_address == OFS_INSTR) begin
      illegal <= !is_copy;
    end
  end

  // form latched at issue: 0 selects the byte count, 1 the word count
  always_ff @(posedge clk) begin
    if (rst) begin
      word_form <= 1'b0;
    end else if (start) begin
      word_form <= is_word;                                                  // [RQ13]
    end
  end

  // copy engine
  // the counter in use depends on the form
  assign count_zero = word_form ? (count_register == 16'h0000)               // [RQ3]
                                : (count_register[7:0] == 8'h00);
  assign last_byte  = word_form ? (count_register == 16'h0001)
                                : (count_register[7:0] == 8'h01);

  // overhead phase is a fixed eight states; each byte is four states
  // when memory answers at once, longer when it holds mem_ready low
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= S_IDLE;
    end else begin
      case (state)
        S_IDLE: begin
          if (start) begin
            state <= S_OVERHEAD;
          end
        end
        S_OVERHEAD: begin
          if (overhead_cnt == 4'(OVERHEAD_STATES - 1)) begin                 // [RQ4]
            state <= count_zero ? S_IDLE : S_RD_SETUP;                       // [RQ2]
          end
        end
        S_RD_SETUP: state <= S_RD_DATA;
        S_RD_DATA: begin
          if (mem_ready) begin                                               // [RQ5]
            state <= S_WR_SETUP;
          end
        end
        S_WR_SETUP: state <= S_WR_DATA;
        S_WR_DATA: begin
          if (mem_ready) begin                                               // [RQ5]
            state <= last_byte ? S_IDLE : S_RD_SETUP;                        // [RQ1]
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // overhead counter runs only in the overhead phase
  always_ff @(posedge clk) begin
    if (rst) begin
      overhead_cnt <= 4'h0;
    end else if (state == S_OVERHEAD) begin
      overhead_cnt <= overhead_cnt + 4'h1;
    end else begin
      overhead_cnt <= 4'h0;
    end
  end

  // states spent by the last copy, counted from issue to finish
  always_ff @(posedge clk) begin
    if (rst) begin
      state_count <= 32'h0;
    end else if (start) begin
      state_count <= 32'h0;
    end else if (busy) begin
      state_count <= state_count + 32'h1;                                    // [RQ4]
    end
  end

  // byte fetched from the source, held for the write
  always_ff @(posedge clk) begin
    if (rst) begin
      copy_byte <= 8'h00;
    end else if (state == S_RD_DATA && mem_ready) begin
      copy_byte <= mem_readdata;
    end
  end

  // source pointer: software load, or step after each written byte
  always_ff @(posedge clk) begin
    if (rst) begin
      source_pointer <= '0;
    end else if (acc_wr && avs_address == OFS_SRC) begin
      source_pointer <= ADDR_W'(merge_be(32'(source_pointer), avs_writedata, avs_byteenable));
    end else if (state == S_WR_DATA && mem_ready) begin
      source_pointer <= source_pointer + ADDR_W'(1);                         // [RQ1]
    end
  end

  // destination pointer steps together with the source
  always_ff @(posedge clk) begin
    if (rst) begin
      destination_pointer <= '0;
    end else if (acc_wr && avs_address == OFS_DST) begin
      destination_pointer <= ADDR_W'(merge_be(32'(destination_pointer), avs_writedata,
                                              avs_byteenable));
    end else if (state == S_WR_DATA && mem_ready) begin
      destination_pointer <= destination_pointer + ADDR_W'(1);               // [RQ1]
    end
  end

  // count: byte form decrements only the low half and keeps the upper one
  always_ff @(posedge clk) begin
    if (rst) begin
      count_register <= 16'h0000;
    end else if (acc_wr && avs_address == OFS_COUNT) begin
      count_register <= 16'(merge_be({16'h0, count_register}, avs_writedata,
                                     avs_byteenable));
    end else if (state == S_WR_DATA && mem_ready) begin
      if (word_form) begin
        count_register <= count_register - 16'h0001;                         // [RQ3]
      end else begin
        count_register[7:0] <= count_register[7:0] - 8'h01;                  // [RQ15]
      end
    end
  end

  // memory port: read strobe in read phase, write strobe in write phase
  always_comb begin
    mem_read      = (state == S_RD_DATA);
    mem_write     = (state == S_WR_DATA);
    mem_address   = (state == S_WR_DATA || state == S_WR_SETUP) ? destination_pointer
                                                                 : source_pointer;
    mem_writedata = copy_byte;
  end

  // done is sticky; writing a one to it clears it, but a finish in the
  // same cycle wins so no completion is ever lost
  assign done_set = busy && ((state == S_OVERHEAD && overhead_cnt == 4'(OVERHEAD_STATES - 1)
                              && count_zero) ||
                             (state == S_WR_DATA && mem_ready && last_byte));

  always_ff @(posedge clk) begin
    if (rst) begin
      done <= 1'b0;
    end else if (done_set) begin
      done <= 1'b1;
    end else if (start) begin
      done <= 1'b0;
    end else if (acc_wr && avs_address == OFS_STATUS && avs_byteenable[0]
                 && avs_writedata[ST_DONE]) begin
      done <= 1'b0;
    end
  end

  // flag rules
  // operands for the flag unit; a write of the op register applies one rule
  always_ff @(posedge clk) begin
    if (rst) begin
      opnd_a <= 32'h0;
    end else if (acc_wr && avs_address == OFS_OPND_A) begin
      opnd_a <= merge_be(opnd_a, avs_writedata, avs_byteenable);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      opnd_b <= 32'h0;
    end else if (acc_wr && avs_address == OFS_OPND_B) begin
      opnd_b <= merge_be(opnd_b, avs_writedata, avs_byteenable);
    end
  end

  assign flag_load = acc_wr && (avs_address == OFS_FLAGOP) && avs_byteenable[0];

  always_ff @(posedge clk) begin
    if (rst) begin
      flag_op <= 4'h0;
    end else if (flag_load) begin
      flag_op <= avs_writedata[3:0];
    end
  end

  // flag unit sees the op being written so its result lands at the same edge
  always_comb begin
    fl.op     = bcp_flag_op_t'(avs_writedata[FOP_SUB_BIT-1:0]);
    fl.sub    = avs_writedata[FOP_SUB_BIT];
    fl.opnd_a = opnd_a;
    fl.opnd_b = opnd_b;
    fl.ccr_in = ccr;
  end

  // the copy never touches ccr; only software or the flag unit do
  always_ff @(posedge clk) begin
    if (rst) begin
      ccr <= CCR_RESET;
    end else if (flag_load) begin
      ccr <= fl.ccr_out;                                                     // [RQ14]
    end else if (acc_wr && avs_address == OFS_CCR && avs_byteenable[0]) begin
      ccr <= avs_writedata[7:0];
    end
  end

endmodule : bcp_block_copy

//--- sim/bcp_block_copy_asserts.sv
// port assertions for the block copy engine
`timescale 1ns/1ps
module bcp_block_copy_asserts
  import bcp_pkg::*;
#(
  parameter int ADDR_W = 24
) (
  input wire logic              clk,
  input wire logic              rst,
  input wire logic [7:0]        avs_address,
  input wire logic              avs_read,
  input wire logic              avs_write,
  input wire logic              avs_waitrequest,
  input wire logic [ADDR_W-1:0] mem_address,
  input wire logic              mem_read,
  input wire logic              mem_write,
  input wire logic [7:0]        mem_writedata,
  input wire logic [7:0]        mem_readdata,
  input wire logic              mem_ready
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic              phase;
  logic              rd_v;
  logic              wr_v;
  logic [7:0]        byte_q;
  logic [ADDR_W-1:0] rd_last;
  logic [ADDR_W-1:0] wr_last;
  wire issue   = avs_write && !avs_waitrequest && avs_address == OFS_INSTR;
  wire rd_done = mem_read && mem_ready;
  wire wr_done = mem_write && mem_ready;
  // high between a byte's read and its write
  always_ff @(posedge clk) begin
    if (rst) phase <= 1'b0;
    else if (rd_done) phase <= 1'b1;
    else if (wr_done) phase <= 1'b0;
  end
  // last byte and addresses; the valid bits guard them
  always_ff @(posedge clk) begin
    if (rd_done) byte_q <= mem_readdata;
    if (rd_done) rd_last <= mem_address;
    if (wr_done) wr_last <= mem_address;
  end
  // address history restarts with every new copy
  always_ff @(posedge clk) begin
    if (rst || issue) begin
      rd_v <= 1'b0;
      wr_v <= 1'b0;
    end else begin
      rd_v <= rd_v | rd_done;
      wr_v <= wr_v | wr_done;
    end
  end
  a_rd_then_wr: assert property ((mem_read || mem_write) |-> mem_write == phase)
    else $error("memory read and write out of turn");
  a_wr_data_match: assert property (mem_write |-> mem_writedata == byte_q)
    else $error("written byte differs from byte read");
  a_rd_addr_up: assert property (rd_done && rd_v |-> mem_address == rd_last + 1'b1)
    else $error("source address not one above previous");
  a_wr_addr_up: assert property (wr_done && wr_v |-> mem_address == wr_last + 1'b1)
    else $error("destination address not one above previous");
  a_byte_pace: assert property (rd_done |=> !mem_read && !mem_write ##1 mem_write)
    else $error("write phase not two cycles after read");
  a_rd_stall_hold: assert property (mem_read && !mem_ready |=> mem_read && $stable(mem_address))
    else $error("read dropped while memory stalls");
  a_wr_stall_hold: assert property (mem_write && !mem_ready |=> mem_write &&
    $stable(mem_address) && $stable(mem_writedata))
    else $error("write dropped while memory stalls");
  a_reg_answer: assert property (avs_read && avs_waitrequest |=> !avs_waitrequest)
    else $error("register read not answered next cycle");
  c_copy_write: cover property (wr_done);
  c_stalled_read: cover property (mem_read && !mem_ready);
  c_issue: cover property (issue);
endmodule : bcp_block_copy_asserts

bind bcp_block_copy bcp_block_copy_asserts #(.ADDR_W(ADDR_W)) bcp_block_copy_asserts_i (
  .clk, .rst, .avs_address, .avs_read, .avs_write, .avs_waitrequest, .mem_address,
  .mem_read, .mem_write, .mem_writedata, .mem_readdata, .mem_ready);

//--- sim/bcp_mem_model.sv
// byte memory on the far side of the copy engine, with optional stalls
`timescale 1ns/1ps
module bcp_mem_model #(
  parameter int ADDR_W = 24
) (
  input  wire logic              clk,
  input  wire logic              slow,
  input  wire logic [ADDR_W-1:0] mem_address,
  input  wire logic              mem_read,
  input  wire logic              mem_write,
  input  wire logic [7:0]        mem_writedata,
  output logic      [7:0]        mem_readdata,
  output logic                   mem_ready
);
  logic [7:0] mem [1024];
  logic [7:0] last = 8'h00;
  logic [1:0] beat = 2'h0;
  int         n_wr = 0;
  // fill with a pattern the bench can recompute
  initial for (int i = 0; i < 1024; i++) mem[i] = 8'(i) ^ 8'h5a;
  // slow mode answers one cycle in three, like a peripheral-paced access
  assign mem_ready = !slow || beat == 2'h2;
  // idle data is the inverse of the last byte so stale data cannot pass
  assign mem_readdata = mem_read ? mem[mem_address[9:0]] : ~last;
  // only ten address bits decode; the bench keeps its regions below 1 KiB
  always @(posedge clk) begin
    beat <= (beat == 2'h2) ? 2'h0 : beat + 2'h1;
    if (mem_read && mem_ready) last <= mem[mem_address[9:0]];
    if (mem_write && mem_ready) begin
      mem[mem_address[9:0]] <= mem_writedata;
      n_wr <= n_wr + 1;
    end
  end
endmodule : bcp_mem_model

//--- sim/tb.sv
// self-checking bench for the block copy engine and its flag rules
`timescale 1ns/1ps
module tb;
  import bcp_pkg::*;
  typedef struct packed {
    logic [3:0]  fop;
    logic [31:0] a;
    logic [31:0] b;
    logic [7:0]  ci;
    logic [7:0]  co;
  } bcp_row_t;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        slow = 1'b0;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [23:0] mem_address;
  logic        mem_read;
  logic        mem_write;
  logic        mem_ready;
  logic [7:0]  mem_writedata;
  logic [7:0]  mem_readdata;
  int          n_mismatch = 0;
  int          n_compared = 0;
  // fop is {subtract, op}; co is the flag byte expected afterwards
  bcp_row_t rows [18] = '{
    {4'h1, 32'h800, 32'h800, 8'h80, 8'ha0}, {4'h1, 32'h7ff, 32'h1, 8'ha0, 8'h80},
    {4'h9, 32'h0, 32'h1, 8'h80, 8'ha0}, {4'h2, 32'h0800_0000, 32'h0800_0000, 8'h80, 8'ha0},
    {4'h2, 32'h800, 32'h800, 8'ha0, 8'h80}, {4'h3, 32'h0, 32'h0, 8'h84, 8'h84},
    {4'h3, 32'h1, 32'h0, 8'h84, 8'h80}, {4'h3, 32'h0, 32'h0, 8'h80, 8'h80},
    {4'h4, 32'h9a, 32'h0, 8'h80, 8'h81}, {4'h4, 32'h12, 32'h0, 8'h81, 8'h81},
    {4'h4, 32'h12, 32'h0, 8'h80, 8'h80}, {4'h5, 32'h0, 32'h8000, 8'h80, 8'h88},
    {4'h5, 32'h0, 32'h1, 8'h88, 8'h80}, {4'h6, 32'h0, 32'h0, 8'h80, 8'h84},
    {4'h6, 32'h0, 32'h5, 8'h84, 8'h80}, {4'h7, 32'h8000_0000, 32'h1, 8'h80, 8'h88},
    {4'h7, 32'h8000_0000, 32'h0, 8'h88, 8'h80}, {4'h0, 32'h0, 32'h0, 8'h8f, 8'h8f}};

  always #4 clk = ~clk;

  bcp_block_copy #(.ADDR_W(24)) bcp_block_copy_i (
    .clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest, .mem_address, .mem_read,
    .mem_write, .mem_writedata, .mem_readdata, .mem_ready);
  bcp_mem_model #(.ADDR_W(24)) bcp_mem_model_i (
    .clk, .slow, .mem_address, .mem_read, .mem_write, .mem_writedata, .mem_readdata,
    .mem_ready);

  task automatic end_of_test;
    $display("mismatches %0d of %0d compared", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test

  // one avalon access, held until waitrequest is sampled low at an edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= d;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic chk_rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, exp, what);
  endtask : chk_rd

  // one copy, then its pointers, count, timing, flags and bytes
  task automatic copy(input logic [23:0] s, input logic [23:0] d, input logic [15:0] c,
                      input logic w);
    logic [31:0] q;
    int          n;
    int          wr0;
    int          ok;
    n = w ? int'(c) : int'(c[7:0]);
    wr0 = bcp_mem_model_i.n_wr;
    ok = 1;
    q = 32'h1;
    wr(OFS_SRC, {8'h0, s});
    wr(OFS_DST, {8'h0, d});
    wr(OFS_COUNT, {16'h0, c});
    wr(OFS_CCR, 32'hab);
    wr(OFS_INSTR, {OPC_COPY_FIRST, w, 23'h0});
    while (q[ST_BUSY] !== 1'b0) bus(1'b0, OFS_STATUS, 32'h0, q);
    chk(q & 32'h3, 32'h2, "copy finished");
    chk_rd(OFS_SRC, 32'(s) + 32'(n), "source pointer");
    chk_rd(OFS_DST, 32'(d) + 32'(n), "destination pointer");
    chk_rd(OFS_COUNT, w ? 32'h0 : {16'h0, c[15:8], 8'h0}, "count");
    chk_rd(OFS_CCR, 32'hab, "flags kept");
    bus(1'b0, OFS_STATES, 32'h0, q);
    if (!slow) chk(q, 32'(OVERHEAD_STATES + STATES_PER_BYTE * n), "states");
    else chk({31'h0, q > 32'(OVERHEAD_STATES + STATES_PER_BYTE * n)}, 32'h1, "stretch");
    for (int k = 0; k < n; k++)
      if (bcp_mem_model_i.mem[10'(d + k)] !== (8'(s + k) ^ 8'h5a)) ok = 0;
    chk(32'(ok), 32'h1, "copied bytes");
    chk(32'(bcp_mem_model_i.n_wr - wr0), 32'(n), "byte writes");
  endtask : copy

  // watchdog at several times the expected run
  initial begin
    repeat (30000) @(posedge clk);
    n_mismatch++;
    end_of_test();
  end

  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      wr(OFS_CCR, {24'h0, rows[i].ci});
      wr(OFS_OPND_A, rows[i].a);
      wr(OFS_OPND_B, rows[i].b);
      wr(OFS_FLAGOP, {28'h0, rows[i].fop});
      chk_rd(OFS_CCR, {24'h0, rows[i].co}, $sformatf("flag row %0d", i));
    end
    copy(24'h000010, 24'h000380, 16'h1203, 1'b0);
    copy(24'h000100, 24'h000390, 16'h0100, 1'b0);
    copy(24'h000000, 24'h0003a0, 16'h0000, 1'b1);
    wr(OFS_STATES, 32'hff);
    chk_rd(OFS_STATES, 32'(OVERHEAD_STATES), "states read-only");
    @(posedge clk);
    slow <= 1'b1;
    copy(24'h000000, 24'h000200, 16'h0101, 1'b1);
    // a wrong first byte must not start a copy
    wr(OFS_INSTR, 32'h7a00_0000);
    chk_rd(OFS_STATUS, 32'h0000_000e, "illegal code");
    wr(8'h40, 32'hffff_ffff);
    chk_rd(8'h40, 32'h0, "unmapped");
    // second reset, with no copy running, brings the flags back
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    chk_rd(OFS_CCR, 32'(CCR_RESET), "flags after reset");
    end_of_test();
  end
endmodule : tb
